// >>> core/ibcs_pkg.sv
// Constants for the two-wire bus control and status block.
// Assumes an APB slave on an 18-bit byte address and a 100 MHz ref_clk.
package ibcs_pkg;

    // Byte address is four times the register index
    localparam int          ADDR_W      = 18;
    localparam logic [15:0] IDX_MODE    = 16'hFF60;  // Channel mode (enable bit)
    localparam logic [15:0] IDX_BCS     = 16'hFF61;  // Bus control and status
    localparam logic [15:0] IDX_IRQ_ST  = 16'hFF68;  // Sticky event status
    localparam logic [15:0] IDX_IRQ_MSK = 16'hFF69;  // Event mask
    localparam logic [15:0] IDX_BITOP   = 16'hFF6A;  // Single-bit write port

    // Bus control and status field positions
    localparam int B_STOP_TRIG  = 0;
    localparam int B_START_TRIG = 1;
    localparam int B_STOP_DET   = 2;
    localparam int B_START_DET  = 3;
    localparam int B_MAN_ACK    = 4;
    localparam int B_AUTO_ACK   = 5;
    localparam int B_ACK_DET    = 6;
    localparam int B_DRAIN_DIS  = 7;

    // Mode register: channel enable position
    localparam int B_CH_EN = 7;

    // Single-bit write port: value bit and index field
    localparam int BOP_VAL = 3;
    localparam int BOP_IW  = 3;

    // Event status positions
    localparam int I_START = 0;
    localparam int I_STOP  = 1;
    localparam int I_ACK   = 2;
    localparam int IRQ_W   = 3;

    // Reset values
    localparam logic [7:0]       BCS_RST   = 8'h00;
    localparam logic [7:0]       MODE_RST  = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST   = 3'h0;
    localparam logic             LATCH_RST = 1'b1;

    // Acknowledge drive sequence
    typedef enum logic [1:0]
    {
        ACK_IDLE  = 2'b00,
        ACK_ARMED = 2'b01,
        ACK_DRIVE = 2'b10
    } ibcs_ack_e;

endpackage

// >>> core/ibcs_line_mon.sv
// Line monitor: synchronises the clock and data lines and finds bus events.
// Assumes both lines are open-drain pins, asynchronous to ref_clk.
`timescale 1ns/1ps
module ibcs_line_mon
(
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic scl_i,     // Bus clock pin
    input  wire logic sda_i,     // Bus data pin
    output logic      scl_rise,  // Bus clock rose
    output logic      scl_fall,  // Bus clock fell
    output logic      start_evt, // Data fell while clock high
    output logic      stop_evt,  // Data rose while clock high
    output logic      sda_s      // Synchronised data level
);

    ////////////////////////////////////////////////////////////////////
    logic [2:0] scl_q;  // Stage 0 is read only by stage 1
    logic [2:0] sda_q;  // Same layout for data

    // Two-flop synchronisers plus one history stage; idle bus is high
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end
        else
        begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Edges compare stages 1 and 2 only, never the metastable stage
    assign scl_rise  = scl_q[1] & ~scl_q[2];
    assign scl_fall  = ~scl_q[1] & scl_q[2];
    // Clock must be high on both samples so a clock edge is not mistaken
    assign start_evt = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    assign stop_evt  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
    assign sda_s     = sda_q[1];

endmodule

// >>> core/ibcs_top.sv
// Bus control and status block of the two-wire serial channel, APB slave.
// Assumes shift logic beside it pulses xfer_start, xfer_done, addr_mismatch.
`timescale 1ns/1ps
module ibcs_top
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    input  wire logic        xfer_start,
    input  wire logic        xfer_done,
    input  wire logic        addr_mismatch,
    output logic             channel_enable,
    output logic             serial_data_out_latch,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////
    logic [7:0]                  mode_r;       // Channel mode register
    logic                        drain_dis_r;  // Transmit output off
    logic                        auto_ack_r;   // Automatic ack enable
    logic                        stop_det_r;   // Stop condition seen
    logic                        start_det_r;  // Start condition seen
    logic                        ack_det_r;    // Ack seen after transfer
    logic                        ack_look_r;   // Waiting for ack rise
    logic                        latch_r;      // Serial data out latch
    ibcs_pkg::ibcs_ack_e         ack_st_r;     // Ack drive sequence
    logic [ibcs_pkg::IRQ_W-1:0]  irq_st_r;     // Sticky events
    logic [ibcs_pkg::IRQ_W-1:0]  irq_msk_r;    // Event mask
    logic [31:0]                 prdata_r;     // Read data
    logic                        pslverr_r;    // Unmapped access
    logic                        oe_n_r;       // Data pin enable, low drives
    logic                        en;           // Channel enabled
    logic                        scl_rise;
    logic                        scl_fall;
    logic                        start_evt;
    logic                        stop_evt;
    logic                        sda_s;
    logic [7:0]                  bcs_rd;       // Read view of control
    logic [7:0]                  wmask;        // Bits touched by a write
    logic [7:0]                  wval;         // Values for touched bits
    logic                        acc_wr;       // APB write access phase
    logic                        stop_trig;
    logic                        start_trig;
    logic                        man_ack;
    logic                        drive_low;
    logic [31:0]                 rd_mux;
    logic                        rd_hit;

    // Register index match; byte address is index times four
    function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
        return a == {idx, 2'b00};
    endfunction

    ////////////////////////////////////////////////////////////////////
    ibcs_line_mon ibcs_line_mon_i
    (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_evt (start_evt),
        .stop_evt  (stop_evt),
        .sda_s     (sda_s)
    );

    ////////////////////////////////////////////////////////////////////
    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign acc_wr = psel & penable & pwrite;
    assign en     = mode_r[ibcs_pkg::B_CH_EN];

    // Whole byte, or one bit chosen through the bit port
    always_comb
    begin
        wmask = 8'h00;
        wval  = 8'h00;
        if (acc_wr && hit(paddr, ibcs_pkg::IDX_BCS))
        begin
            wmask = 8'hFF;
            wval  = pwdata[7:0];
        end
        else if (acc_wr && hit(paddr, ibcs_pkg::IDX_BITOP))
        begin
            wmask = 8'h01 << pwdata[ibcs_pkg::BOP_IW-1:0];
            wval  = {8{pwdata[ibcs_pkg::BOP_VAL]}};
        end
    end

    // Triggers are pulses, never stored, so they read back as zero
    assign stop_trig  = en & wmask[ibcs_pkg::B_STOP_TRIG] & wval[ibcs_pkg::B_STOP_TRIG];
    assign start_trig = en & wmask[ibcs_pkg::B_START_TRIG] & wval[ibcs_pkg::B_START_TRIG];
    assign man_ack    = en & wmask[ibcs_pkg::B_MAN_ACK] & wval[ibcs_pkg::B_MAN_ACK];

    // Read view; trigger positions are constant zero
    assign bcs_rd = {drain_dis_r, ack_det_r, auto_ack_r, 1'b0,
                     start_det_r, stop_det_r, 2'b00};

    ////////////////////////////////////////////////////////////////////
    // Channel mode: only the enable bit is held here
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            mode_r <= ibcs_pkg::MODE_RST;
        else if (acc_wr && hit(paddr, ibcs_pkg::IDX_MODE))
            mode_r <= {pwdata[ibcs_pkg::B_CH_EN], 7'h00};
    end

    // Software-owned control bits; neither is cleared by hardware
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            drain_dis_r <= ibcs_pkg::BCS_RST[ibcs_pkg::B_DRAIN_DIS];
            auto_ack_r  <= ibcs_pkg::BCS_RST[ibcs_pkg::B_AUTO_ACK];
        end
        else
        begin
            if (wmask[ibcs_pkg::B_DRAIN_DIS])
                drain_dis_r <= wval[ibcs_pkg::B_DRAIN_DIS];
            if (wmask[ibcs_pkg::B_AUTO_ACK])
                auto_ack_r <= wval[ibcs_pkg::B_AUTO_ACK];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stop flag; detection wins over a same-cycle transfer clear
    always_ff @(posedge ref_clk)
    begin
        if (srst || !en)
            stop_det_r <= 1'b0;
        else if (stop_evt)
            stop_det_r <= 1'b1;
        else if (xfer_start || addr_mismatch)
            stop_det_r <= 1'b0;
    end

    // Start flag; a stop condition ends the bus ownership it marks
    always_ff @(posedge ref_clk)
    begin
        if (srst || !en)
            start_det_r <= 1'b0;
        else if (start_evt)
            start_det_r <= 1'b1;
        else if (xfer_start || stop_evt)
            start_det_r <= 1'b0;
    end

    // Ack window opens at transfer end and closes at the next rise
    always_ff @(posedge ref_clk)
    begin
        if (srst || !en || xfer_start)
            ack_look_r <= 1'b0;
        else if (xfer_done)
            ack_look_r <= 1'b1;
        else if (scl_rise)
            ack_look_r <= 1'b0;
    end

    // Ack flag: data low on the rise that closes the window
    always_ff @(posedge ref_clk)
    begin
        if (srst || !en)
            ack_det_r <= 1'b0;
        else if (ack_look_r && scl_rise && !sda_s)
            ack_det_r <= 1'b1;
        else if (xfer_start)
            ack_det_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Data out latch idles high so the line is released after reset
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            latch_r <= ibcs_pkg::LATCH_RST;
        else if (stop_trig)
            latch_r <= 1'b1;
        else if (start_trig)
            latch_r <= 1'b0;
    end

    // Ack drive: manual starts at once, auto waits for the eighth fall;
    // either way the line is released at the ninth fall
    always_ff @(posedge ref_clk)
    begin
        if (srst || !en || xfer_start)
            ack_st_r <= ibcs_pkg::ACK_IDLE;
        else
        begin
            case (ack_st_r)
                ibcs_pkg::ACK_IDLE:
                begin
                    if (man_ack)
                        ack_st_r <= ibcs_pkg::ACK_DRIVE;
                    else if (xfer_done && auto_ack_r)
                        ack_st_r <= ibcs_pkg::ACK_ARMED;
                end
                ibcs_pkg::ACK_ARMED:
                begin
                    if (man_ack || scl_fall)
                        ack_st_r <= ibcs_pkg::ACK_DRIVE;
                end
                ibcs_pkg::ACK_DRIVE:
                begin
                    // A new manual request holds the line another clock
                    if (scl_fall && !man_ack)
                        ack_st_r <= ibcs_pkg::ACK_IDLE;
                end
                default:
                    ack_st_r <= ibcs_pkg::ACK_IDLE;
            endcase
        end
    end

    // Open-drain data pin; the transmit path obeys the drain disable
    assign drive_low = en & ((~latch_r & ~drain_dis_r) | (ack_st_r == ibcs_pkg::ACK_DRIVE));

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            oe_n_r <= 1'b1;
        else
            oe_n_r <= ~drive_low;
    end

    assign sda_o                 = 1'b0;
    assign sda_oe_n              = oe_n_r;
    assign channel_enable        = en;
    assign serial_data_out_latch = latch_r;

    ////////////////////////////////////////////////////////////////////
    // Sticky events; a new event beats a same-cycle write-one clear
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            irq_st_r <= ibcs_pkg::IRQ_RST;
        else
        begin
            for (int i = 0; i < ibcs_pkg::IRQ_W; i++)
            begin
                if (acc_wr && hit(paddr, ibcs_pkg::IDX_IRQ_ST) && pwdata[i])
                    irq_st_r[i] <= 1'b0;
            end
            if (en && start_evt)
                irq_st_r[ibcs_pkg::I_START] <= 1'b1;
            if (en && stop_evt)
                irq_st_r[ibcs_pkg::I_STOP] <= 1'b1;
            if (en && ack_look_r && scl_rise && !sda_s)
                irq_st_r[ibcs_pkg::I_ACK] <= 1'b1;
        end
    end

    // Mask register
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            irq_msk_r <= ibcs_pkg::IRQ_RST;
        else if (acc_wr && hit(paddr, ibcs_pkg::IDX_IRQ_MSK))
            irq_msk_r <= pwdata[ibcs_pkg::IRQ_W-1:0];
    end

    assign irq = |(irq_st_r & irq_msk_r);

    ////////////////////////////////////////////////////////////////////
    // Read decode; unmapped addresses read zero with an error
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        if (hit(paddr, ibcs_pkg::IDX_MODE))
            rd_mux = {24'h00_0000, mode_r};
        else if (hit(paddr, ibcs_pkg::IDX_BCS))
            rd_mux = {24'h00_0000, bcs_rd};
        else if (hit(paddr, ibcs_pkg::IDX_IRQ_ST))
            rd_mux = {29'h0000_0000, irq_st_r};
        else if (hit(paddr, ibcs_pkg::IDX_IRQ_MSK))
            rd_mux = {29'h0000_0000, irq_msk_r};
        else if (hit(paddr, ibcs_pkg::IDX_BITOP))
            rd_mux = 32'h0000_0000;
        else
            rd_hit = 1'b0;
    end

    // Captured in the setup cycle so data stand through the access cycle
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_r  <= rd_mux;
            pslverr_r <= ~rd_hit;
        end
    end

    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_man_ack;
        man_ack && !xfer_start ##1 en && !xfer_start;
    endsequence

    // Fall taken while armed, channel still on in the cycle the drive starts
    sequence s_auto_fall;
        ack_st_r == ibcs_pkg::ACK_ARMED && scl_fall && en && !xfer_start ##1 en;
    endsequence

    AST_RESET_ZERO: assert property (disable iff (1'b0) srst |=> bcs_rd == 8'h00)
        else $error("control register not zero after reset");
    AST_BITOP_ISOLATED: assert property (
        acc_wr && hit(paddr, ibcs_pkg::IDX_BITOP) && pwdata[2:0] != 3'h7
        |=> drain_dis_r == $past(drain_dis_r))
        else $error("single-bit write changed another bit");
    AST_STOP_LATCH: assert property (stop_trig |=> latch_r)
        else $error("stop trigger did not set latch");
    AST_START_LATCH: assert property (start_trig && !stop_trig |=> !latch_r ##1 !latch_r || stop_trig)
        else $error("start trigger did not clear latch");
    AST_STOP_SET: assert property (en && stop_evt |=> stop_det_r)
        else $error("stop condition not flagged");
    AST_STOP_CLR: assert property (
        (!en || (!stop_evt && (xfer_start || addr_mismatch))) |=> !stop_det_r)
        else $error("stop flag not cleared");
    AST_START_SET: assert property (en && start_evt |=> start_det_r)
        else $error("start condition not flagged");
    AST_START_CLR: assert property (stop_evt || !en |=> !start_det_r)
        else $error("start flag survived stop or disable");
    AST_MAN_ACK: assert property (s_man_ack |=> !sda_oe_n)
        else $error("manual ack did not pull data low");
    AST_ACK_CLR: assert property (xfer_start || !en |=> ack_st_r == ibcs_pkg::ACK_IDLE)
        else $error("ack drive survived start or disable");
    AST_RO_BITS: assert property (
        acc_wr && hit(paddr, ibcs_pkg::IDX_BCS) && en && !stop_evt && !start_evt
        && !xfer_start && !addr_mismatch && !scl_rise
        |=> bcs_rd[6] == $past(bcs_rd[6]) && bcs_rd[3:2] == $past(bcs_rd[3:2]))
        else $error("write altered a read-only flag");
    AST_DISABLED: assert property (!en ##1 !en |=> sda_oe_n && ack_st_r == ibcs_pkg::ACK_IDLE)
        else $error("disabled channel still drives data");
    AST_ACK_DET: assert property (en && ack_look_r && scl_rise && !sda_s |=> ack_det_r)
        else $error("ack not flagged");
    AST_AUTO_ACK: assert property (s_auto_fall |-> ack_st_r == ibcs_pkg::ACK_DRIVE ##1 !sda_oe_n)
        else $error("auto ack not driven at fall");

endmodule

// >>> dv/ibcs_bus_model.sv
// Far side of the two-wire bus: a master making start, stop and clock bits.
// Assumes the block pulls data low while its drive enable is low.
`timescale 1ns/1ps
module ibcs_bus_model
(
    input  wire logic dut_oe_n, // Block's data drive, low = pulls low
    output logic      scl,      // Bus clock, stands high between frames
    output logic      sda       // Resolved data wire
);
    logic rel_r; // Model lets data go when high

    ////////////////////////////////////////////////////////////////////////////
    // Wired-and with a pull-up, so a released wire reads high, never stale
    assign sda = rel_r & dut_oe_n;

    // Idle bus: both lines released
    initial
    begin
        scl   = 1'b1;
        rel_r = 1'b1;
    end

    // Data falls while the clock is high, then the clock drops
    task automatic start_cond();
        rel_r = 1'b0;
        #62.5;
        scl = 1'b0;
        #62.5;
    endtask

    // Data low under a low clock, clock up, then data rises
    task automatic stop_cond();
        rel_r = 1'b0;
        #31.25;
        scl = 1'b1;
        #62.5;
        rel_r = 1'b1;
        #62.5;
    endtask

    // One bit: data changes only while the clock is low
    task automatic clk_bit(input logic b);
        rel_r = b;
        #31.25;
        scl = 1'b1;
        #62.5;
        scl = 1'b0;
        #31.25;
    endtask
endmodule

// >>> dv/ibcs_top_bench.sv
// Self-checking bench of the bus control and status block over APB.
// Assumes the bus model in ibcs_bus_model.sv stands for the far side.
`timescale 1ns/1ps
module ibcs_top_bench;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        scl;
    logic        sda;
    logic        sda_oe_n;
    logic        sda_o;      // Data pin value, open drain
    logic        xfer_start = 1'b0;
    logic        xfer_done = 1'b0;
    logic        addr_mismatch = 1'b0;
    logic        channel_enable;
    logic        serial_data_out_latch;
    logic        irq;
    logic [31:0] rd;         // Last read data
    logic        er;         // Last error response
    int          err_count = 0;
    int          n_compared = 0;

    ////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    ibcs_top ibcs_top_i
    (
        .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .xfer_start(xfer_start),
        .xfer_done(xfer_done), .addr_mismatch(addr_mismatch),
        .channel_enable(channel_enable),
        .serial_data_out_latch(serial_data_out_latch), .irq(irq)
    );

    ibcs_bus_model ibcs_bus_model_i
    (
        .dut_oe_n(sda_oe_n), .scl(scl), .sda(sda)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Compare a bus value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    // Compare a single output
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready, giving up after 50 cycles
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50)
            chk_bit(1'b0, 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h000000, exp});
    endtask

    // One-cycle pulse from the shift logic: 0 start, 1 done, 2 mismatch
    task automatic pls(input int k);
        @(posedge ref_clk);
        xfer_start    <= (k == 0);
        xfer_done     <= (k == 1);
        addr_mismatch <= (k == 2);
        @(posedge ref_clk);
        {xfer_start, xfer_done, addr_mismatch} <= 3'h0;
    endtask

    // Far-side event, then time for the synchronisers: 0 start, 1 stop, 2 bit
    task automatic bus(input int k);
        if (k == 0)
            ibcs_bus_model_i.start_cond();
        else if (k == 1)
            ibcs_bus_model_i.stop_cond();
        else
            ibcs_bus_model_i.clk_bit(1'b1);
        wt(8);
    endtask

    // Let n edges pass and look where outputs have settled
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: the sequence needs well under 5,000 cycles
    initial
    begin
        #100000;
        err_count++;
        $display("[ERR] %0t: watchdog expired", $time);
        test_done();
    end

    // Main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        rdc(ibcs_pkg::IDX_BCS, 8'h00);
        chk_bit(serial_data_out_latch, 1'b1);
        wr(ibcs_pkg::IDX_BCS, 8'hFF);
        rdc(ibcs_pkg::IDX_BCS, 8'hA0);
        chk_bit(serial_data_out_latch, 1'b1);
        wr(ibcs_pkg::IDX_BCS, 8'h00);
        // Single-bit port: set bit 7, try read-only bit 2, then enable the channel
        wr(ibcs_pkg::IDX_BITOP, 8'h0F);
        rdc(ibcs_pkg::IDX_BCS, 8'h80);
        wr(ibcs_pkg::IDX_BITOP, 8'h0A);
        rdc(ibcs_pkg::IDX_BCS, 8'h80);
        wr(ibcs_pkg::IDX_MODE, 8'h80);
        rdc(ibcs_pkg::IDX_MODE, 8'h80);
        chk_bit(channel_enable, 1'b1);
        // Drain disabled so a low latch cannot fake a start on the wire
        wr(ibcs_pkg::IDX_BCS, 8'h82);
        rdc(ibcs_pkg::IDX_BCS, 8'h80);
        chk_bit(serial_data_out_latch, 1'b0);
        wr(ibcs_pkg::IDX_BCS, 8'h81);
        rdc(ibcs_pkg::IDX_BCS, 8'h80);
        chk_bit(serial_data_out_latch, 1'b1);
        wr(ibcs_pkg::IDX_BITOP, 8'h07);
        rdc(ibcs_pkg::IDX_BCS, 8'h00);
        // Start condition, interrupt masked, unmasked and cleared
        wr(ibcs_pkg::IDX_IRQ_MSK, 8'h06);
        bus(0);
        rdc(ibcs_pkg::IDX_BCS, 8'h08);
        chk_bit(irq, 1'b0);
        wr(ibcs_pkg::IDX_IRQ_MSK, 8'h07);
        wt(1);
        chk_bit(irq, 1'b1);
        wr(ibcs_pkg::IDX_IRQ_ST, 8'h01);
        rdc(ibcs_pkg::IDX_IRQ_ST, 8'h00);
        chk_bit(irq, 1'b0);
        pls(0);
        rdc(ibcs_pkg::IDX_BCS, 8'h00);
        // Manual acknowledge after a transfer, seen at the next clock rise
        pls(1);
        wr(ibcs_pkg::IDX_BCS, 8'h10);
        wt(3);
        chk_bit(sda_oe_n, 1'b0);
        chk_bit(sda_o, 1'b0);
        rdc(ibcs_pkg::IDX_BCS, 8'h00);
        bus(2);
        rdc(ibcs_pkg::IDX_BCS, 8'h40);
        chk_bit(sda_oe_n, 1'b1);
        // Automatic acknowledge from one fall to the next
        wr(ibcs_pkg::IDX_BCS, 8'h20);
        pls(1);
        bus(2);
        chk_bit(sda_oe_n, 1'b0);
        bus(2);
        chk_bit(sda_oe_n, 1'b1);
        rdc(ibcs_pkg::IDX_BCS, 8'h60);
        // Stop and start flags and their clear conditions
        bus(1);
        rdc(ibcs_pkg::IDX_BCS, 8'h64);
        rdc(ibcs_pkg::IDX_IRQ_ST, 8'h06);
        pls(2);
        rdc(ibcs_pkg::IDX_BCS, 8'h60);
        bus(0);
        rdc(ibcs_pkg::IDX_BCS, 8'h68);
        bus(1);
        rdc(ibcs_pkg::IDX_BCS, 8'h64);
        pls(0);
        rdc(ibcs_pkg::IDX_BCS, 8'h20);
        // Disable while an acknowledge is being driven
        bus(0);
        wr(ibcs_pkg::IDX_BCS, 8'h30);
        wr(ibcs_pkg::IDX_MODE, 8'h00);
        wt(3);
        chk_bit(sda_oe_n, 1'b1);
        rdc(ibcs_pkg::IDX_BCS, 8'h20);
        chk_bit(channel_enable, 1'b0);
        wr(ibcs_pkg::IDX_BCS, 8'h22);
        wt(2);
        chk_bit(serial_data_out_latch, 1'b1);
        // Reset in mid-run with channel on, latch low and events pending
        wr(ibcs_pkg::IDX_MODE, 8'h80);
        wr(ibcs_pkg::IDX_BCS, 8'hA2);
        wt(1);
        chk_bit(serial_data_out_latch, 1'b0);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rdc(ibcs_pkg::IDX_BCS, 8'h00);
        rdc(ibcs_pkg::IDX_IRQ_ST, 8'h00);
        chk_bit(serial_data_out_latch, 1'b1);
        chk_bit(channel_enable, 1'b0);
        // Unmapped place: zero data and an error response
        apb(1'b0, 16'hFF70, 8'h00);
        chk(rd, 32'h00000000);
        chk_bit(er, 1'b1);
        test_done();
    end
endmodule
